// file: verilog/chg_defines.svh
// charger register bank constants: offsets, field positions, resets, times
// assumes a 25 MHz clk; included by the design only; the bench uses literal values
// How it works
// - termination enable bit 6, default on
// - watchdog limit bits 5:4, off/40/80/160 s
// - safety timer enable bit 3, 3/5/8/12 h
// - bit 0 keeps charging after termination
// - misc bit 6 doubles timer during power-path
// - misc bit 5 turns battery switch off
// - thermal threshold code 60..120 C, default 11
// - status bits 4:3 report charge state
// - status bit 2 shows power-path active
// - status bit 1 shows input power good
// - status bit 0 shows thermal regulation
// - fault bit 6 on watchdog expiry
// - fault bit 5 on input fault
// - fault bits 4,3 thermal shutdown, battery overvoltage
// - fault bit 2 on safety timer expiry
// - fault bits 1:0 hot/cold, gated by enable
// - read-only fault register at 08h, latched bits 6 and 2 reset zero
// - read-only status at 07h with revision
// - one-time-programmable defaults loaded after reset
// - watchdog holds while input power absent
`ifndef CHG_DEFINES_SVH
`define CHG_DEFINES_SVH
`define CHG_OFF_CVC        8'h04
`define CHG_OFF_TTC        8'h05
`define CHG_OFF_MOC        8'h06
`define CHG_OFF_STATUS     8'h07
`define CHG_OFF_FAULT      8'h08
`define CHG_RST_CVC        8'ha3
`define CHG_RST_TTC        8'h4a
`define CHG_RST_MOC        8'h4b
`define CHG_TTC_TERM_EN    6
`define CHG_TTC_WD_HI      5
`define CHG_TTC_WD_LO      4
`define CHG_TTC_SAFE_EN    3
`define CHG_TTC_SAFE_HI    2
`define CHG_TTC_SAFE_LO    1
`define CHG_TTC_KEEP       0
`define CHG_MOC_DOUBLE     6
`define CHG_MOC_FET_OFF    5
`define CHG_MOC_NTC_EN     3
`define CHG_CLK_HZ         25000000
`define CHG_SEC_PER_HOUR   3600
`define CHG_WD_SEC_40      8'h28
`define CHG_WD_SEC_80      8'h50
`define CHG_WD_SEC_160     8'ha0
`define CHG_SAFE_HRS_3     32'h3
`define CHG_SAFE_HRS_5     32'h5
`define CHG_SAFE_HRS_8     32'h8
`define CHG_SAFE_HRS_12    32'hc
`endif

// file: verilog/chg_pkg.sv
// charger register bank types
// assumes nothing beyond the defines header
package chg_pkg;
  typedef enum logic [2:0] {
    CHG_IDLE, CHG_ADDR, CHG_ACK_A, CHG_REG, CHG_ACK_W, CHG_WDATA,
    CHG_RDATA, CHG_RACK
  } chg_bus_state_t;

  typedef struct packed {
    logic [1:0] charge_state_field;
    logic       power_path_active_flag;
    logic       input_power_good_flag;
    logic       thermal_regulation_flag;
    logic       input_fault_flag;
    logic       thermal_shutdown_flag;
    logic       battery_overvoltage_flag;
    logic       thermistor_hot;
    logic       thermistor_cold;
  } chg_cond_t;

  typedef struct packed {
    logic [4:0] charge_current;
    logic [1:0] precharge_current;
    logic       board_overtemp_enable;
    logic [1:0] watchdog_limit;
    logic [5:0] battery_regulation_voltage;
  } chg_otp_t;

  typedef struct packed {
    logic       term_enable;
    logic       post_termination_keep_charging;
    logic       safety_enable;
    logic [1:0] fast_charge_time_select;
    logic       safety_time_doubling_enable;
    logic       battery_switch_off;
    logic       thermistor_sense_enable;
    logic [1:0] thermal_threshold;
    logic [5:0] battery_regulation_voltage;
    logic [4:0] charge_current;
    logic [1:0] precharge_current;
    logic       board_overtemp_enable;
    logic       watchdog_expired;
    logic       safety_expired;
  } chg_ctrl_t;

  typedef struct packed {
    chg_bus_state_t bus;
    logic           scl_q;
    logic           sda_q;
    logic [3:0]     cnt;
    logic [7:0]     shift;
    logic [7:0]     ptr;
    logic           rw;
    logic           mack;
    logic           drive;
    logic [7:0]     cvc;
    logic [7:0]     ttc;
    logic [7:0]     moc;
    logic           otp_done;
    logic [4:0]     icc;
    logic [1:0]     ipre;
    logic           pcb_en;
    logic [31:0]    tick_cnt;
    logic [7:0]     wd_sec;
    logic           wd_expired;
    logic [31:0]    safe_sec;
    logic           half;
    logic           safe_expired;
  } chg_state_t;
endpackage : chg_pkg

// file: verilog/chg_regs.sv
// charger control/status register bank behind a two-wire serial port
// assumes scl/sda already synchronous to clk; sda is open drain
`timescale 1ns/1ps
`include "chg_defines.svh"
module chg_regs #(
  parameter logic [6:0] DEV_ADDR      = 7'h09,
  parameter logic [1:0] REVISION      = 2'h1, // arbitrary value
  parameter int         TICK_CYCLES   = `CHG_CLK_HZ,
  parameter int         SEC_PER_HOUR  = `CHG_SEC_PER_HOUR
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              scl_in,
  input  wire logic              sda_in,
  output logic                   sda_out,
  output logic                   sda_oe_n,
  input  wire logic              watchdog_reset,
  input  wire chg_pkg::chg_cond_t cond,
  input  wire chg_pkg::chg_otp_t  otp,
  output chg_pkg::chg_ctrl_t     ctrl
);
  import chg_pkg::*;

  chg_state_t  st;
  chg_state_t  nx;
  logic        rise;
  logic        fall;
  logic        start_c;
  logic        stop_c;
  logic        tick;
  logic        wr_en;
  logic [7:0]  rdata;
  logic [7:0]  status_value;
  logic [7:0]  fault_value;
  logic [7:0]  wd_lim;
  logic        wd_hit;
  logic        charging;
  logic        slow;
  logic        step;
  logic [31:0] safe_hrs;
  logic [31:0] safe_lim;
  logic        safe_hit;
  logic [1:0]  ntc_flags;

  // live views, built only from inputs and flops; reading changes nothing
  assign status_value = {1'b0, REVISION,
                         cond.charge_state_field,
                         cond.power_path_active_flag,
                         cond.input_power_good_flag,
                         cond.thermal_regulation_flag};
  assign fault_value  = {1'b0, st.wd_expired,
                         cond.input_fault_flag,
                         cond.thermal_shutdown_flag,
                         cond.battery_overvoltage_flag,
                         st.safe_expired,
                         ntc_flags};
  // sensing off hides both flags
  assign ntc_flags = st.moc[`CHG_MOC_NTC_EN] ?
                     {cond.thermistor_hot, cond.thermistor_cold} : 2'h0;

  always_comb begin
    if (st.ptr == `CHG_OFF_CVC) begin
      rdata = st.cvc;
    end else if (st.ptr == `CHG_OFF_TTC) begin
      rdata = st.ttc;
    end else if (st.ptr == `CHG_OFF_MOC) begin
      rdata = st.moc;
    end else if (st.ptr == `CHG_OFF_STATUS) begin
      rdata = status_value;
    end else if (st.ptr == `CHG_OFF_FAULT) begin
      rdata = fault_value;
    end else begin
      rdata = 8'h00;
    end
  end

  assign rise    = scl_in & ~st.scl_q;
  assign fall    = ~scl_in & st.scl_q;
  assign start_c = scl_in & st.scl_q & st.sda_q & ~sda_in;
  assign stop_c  = scl_in & st.scl_q & ~st.sda_q & sda_in;
  assign wr_en   = fall && st.bus == CHG_WDATA && st.cnt == 4'h8;
  assign tick    = st.tick_cnt == 32'(TICK_CYCLES - 1);

  always_comb begin
    case (st.ttc[`CHG_TTC_WD_HI:`CHG_TTC_WD_LO])
      2'h1:    wd_lim = `CHG_WD_SEC_40;
      2'h2:    wd_lim = `CHG_WD_SEC_80;
      2'h3:    wd_lim = `CHG_WD_SEC_160;
      default: wd_lim = 8'h00;
    endcase
    case (st.ttc[`CHG_TTC_SAFE_HI:`CHG_TTC_SAFE_LO])
      2'h0:    safe_hrs = `CHG_SAFE_HRS_3;
      2'h1:    safe_hrs = `CHG_SAFE_HRS_5;
      2'h2:    safe_hrs = `CHG_SAFE_HRS_8;
      default: safe_hrs = `CHG_SAFE_HRS_12;
    endcase
  end

  // watchdog stalls with no input power; expiry stops it until reset
  assign wd_hit = tick && cond.input_power_good_flag && wd_lim != 8'h00
                  && !st.wd_expired && st.wd_sec + 8'h01 == wd_lim;
  assign charging = cond.charge_state_field == 2'h1 ||
                    cond.charge_state_field == 2'h2;
  // doubling by half-rate counting keeps the compare at one width
  assign slow = cond.power_path_active_flag &&
                st.moc[`CHG_MOC_DOUBLE];
  assign step = tick && (!slow || st.half);
  assign safe_lim = 32'(safe_hrs * 32'(SEC_PER_HOUR));
  assign safe_hit = charging && st.ttc[`CHG_TTC_SAFE_EN] && step &&
                    !st.safe_expired && st.safe_sec + 32'h1 >= safe_lim;

  always_comb begin
    nx = st;
    nx.scl_q = scl_in;
    nx.sda_q = sda_in;
    // defaults come from the fuse image on the first edge after reset
    if (!st.otp_done) begin
      nx.otp_done = 1'b1;
      nx.cvc[7:2] = otp.battery_regulation_voltage;
      nx.ttc[`CHG_TTC_WD_HI:`CHG_TTC_WD_LO] = otp.watchdog_limit;
      nx.icc      = otp.charge_current;
      nx.ipre     = otp.precharge_current;
      nx.pcb_en   = otp.board_overtemp_enable;
    end
    case (st.bus)
      CHG_ADDR, CHG_REG, CHG_WDATA: begin
        if (rise) begin
          nx.shift = {st.shift[6:0], sda_in};
          nx.cnt   = st.cnt + 4'h1;
        end else if (fall && st.cnt == 4'h8) begin
          nx.cnt = 4'h0;
          if (st.bus == CHG_ADDR) begin
            if (st.shift[7:1] == DEV_ADDR) begin
              nx.drive = 1'b1;
              nx.rw    = st.shift[0];
              nx.bus   = CHG_ACK_A;
            end else begin
              nx.bus = CHG_IDLE;
            end
          end else begin
            nx.drive = 1'b1;
            nx.bus   = CHG_ACK_W;
            if (st.bus == CHG_REG) begin
              nx.ptr = st.shift;
            end else begin
              nx.ptr = st.ptr + 8'h01;
              // status and fault ignore writes
              if (st.ptr == `CHG_OFF_CVC) begin
                nx.cvc = st.shift;
              end else if (st.ptr == `CHG_OFF_TTC) begin
                nx.ttc = st.shift;
              end else if (st.ptr == `CHG_OFF_MOC) begin
                nx.moc = st.shift;
              end
            end
          end
        end
      end
      CHG_ACK_A, CHG_RACK: begin
        if (rise && st.bus == CHG_RACK) begin
          nx.mack = ~sda_in;
        end else if (fall) begin
          nx.drive = 1'b0;
          if (st.bus == CHG_ACK_A && !st.rw) begin
            nx.bus = CHG_REG;
          end else if (st.bus == CHG_ACK_A || st.mack) begin
            nx.drive = ~rdata[7];
            nx.shift = {rdata[6:0], 1'b0};
            nx.cnt   = 4'h1;
            nx.ptr   = st.ptr + 8'h01;
            nx.bus   = CHG_RDATA;
          end else begin
            nx.bus = CHG_IDLE;
          end
        end
      end
      CHG_ACK_W: begin
        if (fall) begin
          nx.drive = 1'b0;
          nx.bus   = CHG_WDATA;
        end
      end
      CHG_RDATA: begin
        if (fall) begin
          if (st.cnt == 4'h8) begin
            nx.drive = 1'b0;
            nx.bus   = CHG_RACK;
          end else begin
            nx.drive = ~st.shift[7];
            nx.shift = {st.shift[6:0], 1'b0};
            nx.cnt   = st.cnt + 4'h1;
          end
        end
      end
      default: ;
    endcase
    if (start_c) begin
      nx.bus   = CHG_ADDR;
      nx.cnt   = 4'h0;
      nx.drive = 1'b0;
    end else if (stop_c) begin
      nx.bus   = CHG_IDLE;
      nx.drive = 1'b0;
    end

    nx.tick_cnt = tick ? 32'h0 : st.tick_cnt + 32'h1;

    if (wd_lim == 8'h00) begin
      nx.wd_sec = 8'h00;
    end else if (tick && cond.input_power_good_flag && !st.wd_expired) begin
      nx.wd_sec = wd_hit ? 8'h00 : st.wd_sec + 8'h01;
    end
    // expiry beats a coincident reset request
    if (wd_hit) begin
      nx.wd_expired = 1'b1;
    end else if (watchdog_reset) begin
      nx.wd_expired = 1'b0;
      nx.wd_sec     = 8'h00;
    end

    if (tick && slow) begin
      nx.half = ~st.half;
    end
    if (!charging || !st.ttc[`CHG_TTC_SAFE_EN]) begin
      nx.safe_sec = 32'h0;
    end else if (step && !st.safe_expired) begin
      nx.safe_sec = st.safe_sec + 32'h1;
    end
    // flag outlives the charge stop it causes; power loss clears it
    if (safe_hit) begin
      nx.safe_expired = 1'b1;
    end else if (!st.ttc[`CHG_TTC_SAFE_EN] || !cond.input_power_good_flag) begin
      nx.safe_expired = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st     <= '0;
      st.cvc <= `CHG_RST_CVC;
      st.ttc <= `CHG_RST_TTC;
      st.moc <= `CHG_RST_MOC;
    end else begin
      st <= nx;
    end
  end

  assign sda_out  = 1'b0;
  assign sda_oe_n = ~st.drive;
  assign ctrl = '{
    term_enable:                    st.ttc[`CHG_TTC_TERM_EN],
    post_termination_keep_charging: st.ttc[`CHG_TTC_KEEP],
    safety_enable:                  st.ttc[`CHG_TTC_SAFE_EN],
    fast_charge_time_select: st.ttc[`CHG_TTC_SAFE_HI:`CHG_TTC_SAFE_LO],
    safety_time_doubling_enable:    st.moc[`CHG_MOC_DOUBLE],
    battery_switch_off:             st.moc[`CHG_MOC_FET_OFF],
    thermistor_sense_enable:        st.moc[`CHG_MOC_NTC_EN],
    thermal_threshold:              st.moc[1:0],
    battery_regulation_voltage:     st.cvc[7:2],
    charge_current:                 st.icc,
    precharge_current:              st.ipre,
    board_overtemp_enable:          st.pcb_en,
    watchdog_expired:               st.wd_expired,
    safety_expired:                 st.safe_expired
  };

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  wd_power_hold_a: assert property (
    (!cond.input_power_good_flag && wd_lim != 8'h00 && !watchdog_reset)
    |=> st.wd_sec == $past(st.wd_sec)) else $error("watchdog ran unpowered");
  wd_fault_set_a: assert property (wd_hit |=> fault_value[6] &&
    ctrl.watchdog_expired) else $error("watchdog expiry not flagged");
  wd_disabled_a: assert property (
    st.ttc[5:4] == 2'h0 |=> st.wd_sec == 8'h00 && !wd_hit)
    else $error("disabled watchdog counts");
  wd_stuck_a: assert property (
    st.wd_expired && !watchdog_reset |=> st.wd_expired && st.wd_sec == 8'h00)
    else $error("watchdog left expired state");
  safe_off_a: assert property (!st.ttc[3] |=> st.safe_sec == 32'h0
    && !st.safe_expired) else $error("disabled safety timer counts");
  ntc_gate_a: assert property (!st.moc[3] |->
    fault_value[1:0] == 2'h0) else $error("thermistor fault not gated");
  fet_write_a: assert property (wr_en && st.ptr == 8'h06 |=>
    ctrl.battery_switch_off == $past(st.shift[5]))
    else $error("battery switch write lost");
  ro_fault_a: assert property (wr_en && st.ptr == 8'h08 |=>
    st.cvc == $past(st.cvc) && st.ttc == $past(st.ttc)
    && st.moc == $past(st.moc)) else $error("fault register took write");
  status_map_a: assert property (
    st.ptr == 8'h07 |-> rdata[4:3] == cond.charge_state_field &&
    rdata[6:5] == REVISION) else $error("status read wrong");

  wd_expiry_c: cover property (wd_hit);
  safe_expiry_c: cover property (safe_hit ##1 slow);
  reg_write_c: cover property (wr_en && st.ptr == 8'h05);
  reg_read_c: cover property (st.bus == CHG_RACK ##[1:40] st.bus == CHG_RDATA);
endmodule : chg_regs

// file: bench/chg_host.sv
// serial host model for the charger register bank
// assumes the bench resolves sda as open drain with a pull-up
`timescale 1ns/1ps
module chg_host #(
  parameter logic [6:0] ADDR = 7'h09
) (
  input  wire logic clk,
  output logic      scl,
  output logic      sda_rel,
  input  wire logic sda
);
  logic [6:0] dev = ADDR;
  int         naks = 0;
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end
  // 4 clk a phase, twice the device minimum
  task automatic ph();
    repeat (4) @(posedge clk);
  endtask : ph
  // one scl pulse; a != b gives start or stop while scl is high
  task automatic step(input logic a, input logic b, input logic fall,
                      output logic got);
    sda_rel <= a;
    ph();
    scl <= 1'b1;
    ph();
    got = sda;
    sda_rel <= b;
    if (a != b) ph();
    if (fall) scl <= 1'b0;
    if (fall) ph();
  endtask : step
  task automatic xfer(input logic [7:0] tx, input logic last,
                      input logic cnt, output logic [7:0] rx);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      step(tx[i], tx[i], 1'b1, b);
      rx[i] = b;
    end
    step(last, last, 1'b1, b);
    if (cnt) naks += int'(b);
  endtask : xfer
  // pointer write, then burst write or repeated start and burst read
  task automatic xact(input logic rd, input logic [7:0] ra,
                      inout logic [23:0] d, input int n);
    logic [7:0] rx;
    logic       b;
    step(1'b1, 1'b0, 1'b1, b);
    xfer({dev, 1'b0}, 1'b1, 1'b1, rx);
    xfer(ra, 1'b1, 1'b1, rx);
    if (rd) step(1'b1, 1'b0, 1'b1, b);
    if (rd) xfer({dev, 1'b1}, 1'b1, 1'b1, rx);
    for (int i = n - 1; i >= 0; i--) begin
      xfer(rd ? 8'hff : d[8*i +: 8], rd ? i == 0 : 1'b1, !rd, rx);
      if (rd) d[8*i +: 8] = rx;
    end
    step(1'b0, 1'b1, 1'b0, b);
  endtask : xact
endmodule : chg_host

// file: bench/tb.sv
// self-checking bench for the charger register bank
// assumes chg_host as serial host; tick and hour counts shortened
`timescale 1ns/1ps
`define CK(nm, e, g) \
  begin \
    checks_done++; \
    if ((g) !== (e)) begin \
      errors++; \
      $display("mismatch %s exp %h got %h", nm, e, g); \
    end \
  end
module tb;
  import chg_pkg::*;
  localparam int         TICK = 4;
  localparam int         SPH  = 2;
  localparam logic [1:0] REV  = 2'h1; // arbitrary value
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        wd_rst = 1'b0;
  logic        scl;
  logic        sda_rel;
  logic        sda_out;
  logic        sda_oe_n;
  chg_cond_t   cond = '0;
  chg_otp_t    otp = '0;
  chg_ctrl_t   ctrl;
  logic [31:0] seed = 32'h878923c4;
  logic [31:0] r;
  logic [23:0] d;
  logic [7:0]  cvc;
  logic [7:0]  ttc;
  logic [7:0]  moc;
  int          errors = 0;
  int          checks_done = 0;
  // pull-up: any party pulling low wins
  wire sda = sda_rel & (sda_oe_n | sda_out);
  always #20 clk = ~clk;
  chg_host host (.clk(clk), .scl(scl), .sda_rel(sda_rel), .sda(sda));
  chg_regs #(.REVISION(REV), .TICK_CYCLES(TICK), .SEC_PER_HOUR(SPH)) dut (
    .clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .watchdog_reset(wd_rst), .cond(cond), .otp(otp),
    .ctrl(ctrl));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic chg_ctrl_t exp_ctrl(logic w, logic s);
    return {ttc[6], ttc[0], ttc[3], ttc[2:1], moc[6], moc[5], moc[3],
            moc[1:0], cvc[7:2], otp.charge_current, otp.precharge_current,
            otp.board_overtemp_enable, w, s};
  endfunction : exp_ctrl
  // watchdog limit in seconds per code
  function automatic int exp_wd(logic [1:0] c);
    return c == 2'h1 ? 40 : c == 2'h2 ? 80 : c == 2'h3 ? 160 : 0;
  endfunction : exp_wd
  // safety limit in hours per code
  function automatic int exp_hrs(logic [1:0] c);
    return c == 2'h0 ? 3 : c == 2'h1 ? 5 : c == 2'h2 ? 8 : 12;
  endfunction : exp_hrs
  // thermistor flags only count while sensing is enabled
  function automatic logic [15:0] exp_sf(logic w, logic s);
    return {1'b0, REV, cond.charge_state_field, cond.power_path_active_flag,
            cond.input_power_good_flag, cond.thermal_regulation_flag,
            1'b0, w, cond.input_fault_flag, cond.thermal_shutdown_flag,
            cond.battery_overvoltage_flag, s,
            moc[3] ? {cond.thermistor_hot, cond.thermistor_cold} : 2'b00};
  endfunction : exp_sf
  task automatic wr(input logic [7:0] ra, input logic [23:0] v, input int n);
    d = v;
    host.xact(1'b0, ra, d, n);
  endtask : wr
  task automatic rd(input logic [7:0] ra, input int n);
    host.xact(1'b1, ra, d, n);
  endtask : rd
  task automatic setc(input logic [9:0] v);
    @(posedge clk);
    cond <= v;
  endtask : setc
  task automatic wdr();
    @(posedge clk);
    wd_rst <= 1'b1;
    @(posedge clk);
    wd_rst <= 1'b0;
  endtask : wdr
  // counts from enable (safety) or from now (watchdog) to expiry
  task automatic tmeas(input logic sel, input int lo, input int hi);
    int n;
    n = 0;
    while (sel && ctrl.safety_enable !== 1'b1 && n < 500) begin
      @(negedge clk);
      n++;
    end
    if (sel) `CK("enable_seen", 1'b1, n < 500)
    if (n >= 500) results();
    n = 0;
    while ((sel ? ctrl.safety_expired : ctrl.watchdog_expired) !== 1'b1
           && n < 1000) begin
      @(negedge clk);
      n++;
    end
    `CK("timer_len", 1'b1, n >= lo && n <= hi)
    if (n >= 1000) results();
  endtask : tmeas
  task automatic fin(input string s);
    $display("test %s done", s);
  endtask : fin
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results
  initial begin
    int nk;
    int w;
    r = rnd();
    otp <= r[15:0];
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    cvc = {otp.battery_regulation_voltage, 2'b11};
    ttc = {2'b01, otp.watchdog_limit, 4'ha};
    moc = 8'h4b;
    `CK("ctrl_rst", exp_ctrl(1'b0, 1'b0), ctrl)
    rd(8'h04, 3);
    `CK("regs_rst", {cvc, ttc, moc}, d)
    rd(8'h07, 2);
    `CK("stat_rst", exp_sf(1'b0, 1'b0), d[15:0])
    fin("defaults");
    for (int i = 0; i < 6; i++) begin
      r = rnd();
      cvc = r[23:16];
      ttc = {r[7:6], i[1:0], r[3], i[1:0], r[0]};
      moc = {r[15:10], i[1:0]};
      wr(8'h04, {cvc, ttc, moc}, 3);
      rd(8'h04, 3);
      `CK("regs_rw", {cvc, ttc, moc}, d)
      `CK("ctrl_rw", exp_ctrl(1'b0, 1'b0), ctrl)
    end
    fin("control");
    nk = host.naks;
    host.dev = 7'h0a;
    wr(8'h04, 24'h0000aa, 1);
    host.dev = 7'h09;
    `CK("bad_addr", 3, host.naks - nk)
    wr(8'h07, 24'h00ffff, 2);
    rd(8'h20, 1);
    `CK("unmapped", 8'h00, d[7:0])
    rd(8'h04, 1);
    `CK("cvc_kept", cvc, d[7:0])
    fin("refusals");
    ttc = 8'h40;
    wr(8'h05, ttc, 1);
    wdr();
    for (int i = 0; i < 4; i++) begin
      r = rnd();
      moc = {4'h4, i[1], 3'h3};
      wr(8'h06, moc, 1);
      setc({i[1:0], r[7:0]});
      rd(8'h07, 2);
      `CK("stat_fault", exp_sf(1'b0, 1'b0), d[15:0])
      rd(8'h07, 2);
      `CK("stat_again", exp_sf(1'b0, 1'b0), d[15:0])
    end
    fin("status");
    setc(10'h040);
    wr(8'h05, 24'h50, 1);
    wdr();
    tmeas(1'b0, 40 * TICK - 8, 40 * TICK + 8);
    rd(8'h08, 1);
    `CK("wd_fault", 1'b1, d[6])
    setc(10'h000);
    wdr();
    repeat (300) @(negedge clk);
    `CK("wd_held", 1'b0, ctrl.watchdog_expired)
    setc(10'h040);
    tmeas(1'b0, 40 * TICK - 8, 40 * TICK + 8);
    wr(8'h05, 24'h40, 1);
    wdr();
    for (int c = 2; c < 4; c++) begin
      wr(8'h05, {16'h0, 2'b01, c[1:0], 4'h0}, 1);
      wdr();
      w = exp_wd(c[1:0]) * TICK;
      tmeas(1'b0, w - 8, w + 8);
      wr(8'h05, 24'h40, 1);
      wdr();
    end
    fin("watchdog");
    setc(10'h240);
    wr(8'h06, 24'h0b, 1);
    fork
      wr(8'h05, 24'h48, 1);
      tmeas(1'b1, 3 * SPH * TICK - 4, 3 * SPH * TICK + 6);
    join
    rd(8'h08, 1);
    `CK("safe_fault", 1'b1, d[2])
    for (int c = 1; c < 4; c++) begin
      wr(8'h05, 24'h40, 1);
      w = exp_hrs(c[1:0]) * SPH * TICK;
      fork
        wr(8'h05, {16'h0, 4'h4, 1'b1, c[1:0], 1'b0}, 1);
        tmeas(1'b1, w - 4, w + 6);
      join
    end
    wr(8'h05, 24'h40, 1);
    setc(10'h2c0);
    wr(8'h06, 24'h4b, 1);
    fork
      wr(8'h05, 24'h48, 1);
      tmeas(1'b1, 6 * SPH * TICK - 8, 6 * SPH * TICK + 8);
    join
    fin("safety");
    results();
  end
endmodule : tb
